// ===== wdcu_checker.sv
// port-level checks of the watchdog control block
`timescale 1ns/10ps
module wdcu_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        chip_reset_req,
	input wire logic        chip_reset_scope
);
	logic [6:0] len_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles the chip reset request has been high so far
	always @(posedge aclk) begin
		if (!aresetn)
			len_r <= 7'h00;
		else
			len_r <= chip_reset_req ? len_r + 7'h01 : 7'h00;
	end
	wr_resp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'h0)
		else $error("read answer late or not okay");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	rst_len_a: assert property (chip_reset_req |-> len_r < 7'h3f)
		else $error("chip reset request too long");
	rst_end_a: assert property ($fell(chip_reset_req) |-> len_r == 7'h3f)
		else $error("chip reset request too short");
	scope_hold_a: assert property (chip_reset_req && $past(chip_reset_req) |-> $stable(chip_reset_scope))
		else $error("reset scope changed during request");
endmodule

bind wdcu_top wdcu_checker i_wdcu_checker (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .chip_reset_req, .chip_reset_scope);

// ===== wdcu_defs.vh
// register map, field positions, reset values and timing counts of the watchdog control block
`ifndef WDCU_DEFS_VH
`define WDCU_DEFS_VH

// byte offsets on the register bus
`define WDCU_OFS_CONTROL     4'h0
`define WDCU_OFS_DELAY_SEL   4'h4
`define WDCU_OFS_IRQ_STATUS  4'h8
`define WDCU_OFS_IRQ_MASK    4'hc

// watchdog_control field positions
`define WDCU_BIT_DBG_IGNORE  31
`define WDCU_BIT_TIMEOUT     16
`define WDCU_BIT_SCOPE       12
`define WDCU_TSEL_HI         11
`define WDCU_TSEL_LO         8
`define WDCU_BIT_ENABLE      7
`define WDCU_BIT_RST_FLAG    2
`define WDCU_BIT_RST_EN      1
`define WDCU_BIT_CNT_CLEAR   0

// reset values
`define WDCU_CONTROL_RST     32'h00000f00
`define WDCU_TSEL_RST        4'hf

// interval exponents: codes below the break step by two, above it by one
`define WDCU_TSEL_BREAK      4'h5
`define WDCU_EXP_BASE_LO     5'h04
`define WDCU_EXP_BASE_HI     5'h09

// reset delay periods in watchdog clock cycles, selected by delay code 0..3
`define WDCU_DELAY_0         11'h402
`define WDCU_DELAY_1         11'h082
`define WDCU_DELAY_2         11'h012
`define WDCU_DELAY_3         11'h003

// length of the chip reset request in watchdog clock cycles
`define WDCU_RST_HOLD        6'h3f

// interrupt status bit positions
`define WDCU_IRQ_TIMEOUT     0
`define WDCU_IRQ_RESET       1

// bus responses
`define WDCU_RESP_OKAY       2'h0
`define WDCU_RESP_SLVERR     2'h2

`endif

// ===== wdcu_top.v
// watchdog timer control register block with an axi4-lite register slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "wdcu_defs.vh"

// Overview of operation
// - debug ignore bit 0: counter holds while the probe halts the processor.
// - debug ignore bit 1: counter runs whether or not the processor is halted.
// - timeout flag bit 16 sets when the counter reaches the selected interval.
// - writing 1 clears the timeout flag; writing 0 leaves it.
// - scope bit 12 picks core-domain reset (0) or near whole-chip reset (1).
// - interval select codes give 2^4..2^12 by twos, then 2^14..2^24 by ones.
// - enable bit 7 at 0 stops the watchdog and zeroes the counter.
// - protected fields take writes only while the protection lock is open.
// - writing 1 to counter clear zeroes the counter; the bit self-clears.
// - uncleared after reset delay with reset enabled: set reset flag, reset chip.
module wdcu_top (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        prot_unlocked,
	input  wire        debug_probe_halt,
	output wire        irq,
	output reg         chip_reset_req,
	output reg         chip_reset_scope
);

	// control fields
	reg        dbg_ignore_r;
	reg        timeout_flag_r;
	reg        scope_r;
	reg [3:0]  tsel_r;
	reg        enable_r;
	reg        rst_flag_r;
	reg        rst_en_r;
	reg [1:0]  delay_sel_r;
	reg [1:0]  irq_status_r;
	reg [1:0]  irq_mask_r;

	// counting state
	reg [23:0] cnt_r;
	reg        dly_act_r;
	reg [10:0] dly_cnt_r;
	reg [5:0]  hold_cnt_r;

	// bus state
	reg        aw_held_r;
	reg [3:0]  aw_addr_r;
	reg        w_held_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;

	wire       aw_hs;
	wire       w_hs;
	wire       ar_hs;
	wire       wr_go;
	wire       wr_ctl;
	wire       wr_dsel;
	wire       wr_mask;
	wire       rd_status;
	wire       cnt_clear;
	wire       advance;
	wire       timeout_ev;
	wire       expire;
	wire       reset_ev;
	reg  [4:0] tout_exp;
	wire [24:0] tout_span;
	wire [24:0] tout_last_w;
	wire [23:0] tout_last;
	reg  [10:0] dly_len;
	reg  [31:0] rd_mux;
	reg  [1:0]  rd_resp;
	reg  [1:0]  status_nxt;

	// bus handshakes; one write and one read in flight
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign aw_hs   = s_axi_awvalid & s_axi_awready;
	assign w_hs    = s_axi_wvalid & s_axi_wready;
	assign ar_hs   = s_axi_arvalid & s_axi_arready;
	assign wr_go   = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_ctl  = wr_go & (aw_addr_r == `WDCU_OFS_CONTROL);
	assign wr_dsel = wr_go & (aw_addr_r == `WDCU_OFS_DELAY_SEL);
	assign wr_mask = wr_go & (aw_addr_r == `WDCU_OFS_IRQ_MASK);
	assign rd_status = ar_hs & (s_axi_araddr == `WDCU_OFS_IRQ_STATUS);

	// counter clear strobe: protected write of 1 in the low byte
	assign cnt_clear = wr_ctl & prot_unlocked & w_strb_r[0] & w_data_r[`WDCU_BIT_CNT_CLEAR];

	// counting advances while enabled unless a debug halt freezes it
	assign advance = enable_r & (dbg_ignore_r | ~debug_probe_halt);

	// interval exponent from the select code
	always @* begin
		if (tsel_r < `WDCU_TSEL_BREAK) begin
			tout_exp = `WDCU_EXP_BASE_LO + {tsel_r, 1'b0};
		end else begin
			tout_exp = `WDCU_EXP_BASE_HI + {1'b0, tsel_r};
		end
	end

	// last counter value of the interval, 2^n - 1
	assign tout_span   = 25'h0000001 << tout_exp;
	assign tout_last_w = tout_span - 25'h0000001;
	assign tout_last   = tout_last_w[23:0];
	assign timeout_ev  = advance & ~cnt_clear & (cnt_r == tout_last);

	// reset delay length from the delay select code
	always @* begin
		case (delay_sel_r)
			2'h0: dly_len = `WDCU_DELAY_0;
			2'h1: dly_len = `WDCU_DELAY_1;
			2'h2: dly_len = `WDCU_DELAY_2;
			default: dly_len = `WDCU_DELAY_3;
		endcase
	end

	assign expire   = dly_act_r & advance & ~cnt_clear & (dly_cnt_r == 11'h001);
	assign reset_ev = expire & rst_en_r;

	// up counter: zeroed by disable or clear, else counts while advance is high and holds otherwise
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 24'h000000;
		end else if (!enable_r || cnt_clear) begin
			cnt_r <= 24'h000000;
		end else if (advance) begin
			cnt_r <= cnt_r + 24'h000001;
		end
	end

	// reset delay window opened by each time-out, closed by a counter clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			dly_act_r <= 1'b0;
			dly_cnt_r <= 11'h000;
		end else if (!enable_r || cnt_clear) begin
			dly_act_r <= 1'b0;
		end else if (timeout_ev && !dly_act_r) begin
			dly_act_r <= 1'b1;
			dly_cnt_r <= dly_len;
		end else if (dly_act_r && advance) begin
			dly_cnt_r <= dly_cnt_r - 11'h001;
			if (dly_cnt_r == 11'h001) begin
				dly_act_r <= 1'b0;
			end
		end
	end

	// chip reset request held for a fixed number of cycles
	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_cnt_r       <= 6'h00;
			chip_reset_req   <= 1'b0;
			chip_reset_scope <= 1'b0;
		end else if (reset_ev) begin
			hold_cnt_r       <= `WDCU_RST_HOLD;
			chip_reset_req   <= 1'b1;
			chip_reset_scope <= scope_r;
		end else if (hold_cnt_r != 6'h00) begin
			hold_cnt_r <= hold_cnt_r - 6'h01;
			if (hold_cnt_r == 6'h01) begin
				chip_reset_req <= 1'b0;
			end
		end
	end

	// control and configuration fields; hardware sets win over write-1 clears
	always @(posedge aclk) begin
		if (!aresetn) begin
			dbg_ignore_r   <= 1'b0;
			timeout_flag_r <= 1'b0;
			scope_r        <= 1'b0;
			tsel_r         <= `WDCU_TSEL_RST;
			enable_r       <= 1'b0;
			rst_flag_r     <= 1'b0;
			rst_en_r       <= 1'b0;
			delay_sel_r    <= 2'h0;
			irq_mask_r     <= 2'h0;
		end else begin
			if (wr_ctl && prot_unlocked) begin
				if (w_strb_r[3]) begin
					dbg_ignore_r <= w_data_r[`WDCU_BIT_DBG_IGNORE];
				end
				if (w_strb_r[1]) begin
					scope_r <= w_data_r[`WDCU_BIT_SCOPE];
					tsel_r  <= w_data_r[`WDCU_TSEL_HI:`WDCU_TSEL_LO];
				end
				if (w_strb_r[0]) begin
					enable_r <= w_data_r[`WDCU_BIT_ENABLE];
					rst_en_r <= w_data_r[`WDCU_BIT_RST_EN];
				end
			end
			if (wr_dsel && prot_unlocked && w_strb_r[0]) begin
				delay_sel_r <= w_data_r[1:0];
			end
			if (wr_mask && w_strb_r[0]) begin
				irq_mask_r <= w_data_r[1:0];
			end
			if (timeout_ev) begin
				timeout_flag_r <= 1'b1;
			end else if (wr_ctl && w_strb_r[2] && w_data_r[`WDCU_BIT_TIMEOUT]) begin
				timeout_flag_r <= 1'b0;
			end
			if (reset_ev) begin
				rst_flag_r <= 1'b1;
			end else if (wr_ctl && w_strb_r[0] && w_data_r[`WDCU_BIT_RST_FLAG]) begin
				rst_flag_r <= 1'b0;
			end
		end
	end

	// sticky interrupt status, cleared by a read; a new event wins
	always @* begin
		status_nxt = rd_status ? 2'h0 : irq_status_r;
		if (timeout_ev) begin
			status_nxt[`WDCU_IRQ_TIMEOUT] = 1'b1;
		end
		if (reset_ev) begin
			status_nxt[`WDCU_IRQ_RESET] = 1'b1;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= 2'h0;
		end else begin
			irq_status_r <= status_nxt;
		end
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// write channel capture and response
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r    <= 1'b0;
			aw_addr_r    <= 4'h0;
			w_held_r     <= 1'b0;
			w_data_r     <= 32'h00000000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `WDCU_RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (w_hs) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `WDCU_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read data selection
	always @* begin
		rd_mux  = 32'h00000000;
		rd_resp = `WDCU_RESP_OKAY;
		case ({s_axi_araddr[3:2], 2'b00})
			`WDCU_OFS_CONTROL: begin
				rd_mux[`WDCU_BIT_DBG_IGNORE]          = dbg_ignore_r;
				rd_mux[`WDCU_BIT_TIMEOUT]             = timeout_flag_r;
				rd_mux[`WDCU_BIT_SCOPE]               = scope_r;
				rd_mux[`WDCU_TSEL_HI:`WDCU_TSEL_LO]   = tsel_r;
				rd_mux[`WDCU_BIT_ENABLE]              = enable_r;
				rd_mux[`WDCU_BIT_RST_FLAG]            = rst_flag_r;
				rd_mux[`WDCU_BIT_RST_EN]              = rst_en_r;
			end
			`WDCU_OFS_DELAY_SEL: rd_mux[1:0] = delay_sel_r;
			`WDCU_OFS_IRQ_STATUS: rd_mux[1:0] = irq_status_r;
			`WDCU_OFS_IRQ_MASK: rd_mux[1:0] = irq_mask_r;
			default: rd_resp = `WDCU_RESP_SLVERR;
		endcase
	end

	// read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `WDCU_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ===== wdcu_top_tb.sv
// self-checking bench for the watchdog control block
`timescale 1ns/10ps
`define CK(n, e, v) begin tests_run++; if ((v) !== (e)) begin err_total++; $display("FAIL %s exp %h got %h", n, e, v); end end
module wdcu_top_tb;
	logic        aclk = 0, aresetn = 0, prot_unlocked = 0, debug_probe_halt = 0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        irq, chip_reset_req, chip_reset_scope;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_total = 0, tests_run = 0, cyc = 0;

	wdcu_top i_wdcu_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .prot_unlocked, .debug_probe_halt, .irq, .chip_reset_req, .chip_reset_scope);

	// clock and hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop;
		end
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task w(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// bus write; response ready comes late so the hold is exercised
	task wr(input [3:0] a, input [31:0] v);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			if (n > 2) s_axi_bready <= 1;
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 0;
	endtask

	// bus read into d
	task rd(input [3:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin
			if (n > 2) s_axi_rready <= 1;
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!(s_axi_rvalid && s_axi_rready));
		d = s_axi_rdata;
		s_axi_rready <= 0;
	endtask

	task t_lock;
		wr(4'h0, 32'h00000080);
		rd(4'h0);
		`CK("locked ctrl", 32'h00000f00, d)
		prot_unlocked <= 1;
	endtask

	task t_timeout;
		wr(4'hc, 32'h00000001);
		wr(4'h0, 32'h00000080);
		w(6);
		rd(4'h0);
		`CK("flag early", 1'b0, d[16])
		w(20);
		rd(4'h0);
		`CK("flag", 1'b1, d[16])
		`CK("irq set", 1'b1, irq)
		rd(4'h8);
		`CK("status", 1'b1, d[0])
		`CK("irq clr", 1'b0, irq)
	endtask

	task t_w1c;
		wr(4'h0, 32'h00000000);
		rd(4'h0);
		`CK("w0 flag", 1'b1, d[16])
		wr(4'h0, 32'h00010000);
		rd(4'h0);
		`CK("w1 flag", 1'b0, d[16])
		wr(4'h0, 32'h00000080);
		w(22);
		rd(4'h0);
		`CK("zeroed", 1'b1, d[16])
		wr(4'h0, 32'h00010000);
	endtask

	task t_code;
		wr(4'h0, 32'h00000180);
		w(45);
		rd(4'h0);
		`CK("code1 early", 1'b0, d[16])
		w(30);
		rd(4'h0);
		`CK("code1", 1'b1, d[16])
		wr(4'h0, 32'h00010000);
		// code 5 takes the upper branch of the interval decode: 2^14 cycles
		wr(4'h0, 32'h00000580);
		w(16370);
		rd(4'h0);
		`CK("code5 early", 1'b0, d[16])
		w(10);
		rd(4'h0);
		`CK("code5", 1'b1, d[16])
		wr(4'h0, 32'h00010000);
	endtask

	task t_debug;
		debug_probe_halt <= 1;
		wr(4'h0, 32'h00000080);
		w(40);
		rd(4'h0);
		`CK("frozen", 1'b0, d[16])
		wr(4'h0, 32'h80000080);
		w(30);
		rd(4'h0);
		`CK("ignored", 1'b1, d[16])
		debug_probe_halt <= 0;
		wr(4'h0, 32'h00010000);
	endtask

	task t_clear;
		wr(4'h0, 32'h00000080);
		repeat (4) begin
			w(5);
			wr(4'h0, 32'h00000081);
		end
		rd(4'h0);
		`CK("kept", 1'b0, d[16])
		`CK("clr bit", 1'b0, d[0])
	endtask

	task t_reset;
		int n;
		n = 0;
		wr(4'h4, 32'h00000003);
		wr(4'h0, 32'h00001082);
		while (!chip_reset_req && n < 80) begin
			@(posedge aclk);
			n++;
		end
		`CK("req", 1'b1, chip_reset_req)
		`CK("scope", 1'b1, chip_reset_scope)
		rd(4'h0);
		`CK("rst flag", 1'b1, d[2])
		rd(4'h8);
		`CK("rst status", 1'b1, d[1])
		w(70);
		`CK("req end", 1'b0, chip_reset_req)
	endtask

	// a clear inside the delay window holds the reset off; the next window then fires
	task t_window;
		int n;
		n = 0;
		wr(4'h0, 32'h00010004);
		wr(4'h4, 32'h00000002);
		wr(4'h0, 32'h00000082);
		w(12);
		wr(4'h0, 32'h00000083);
		rd(4'h0);
		`CK("held off", 1'b0, d[2])
		`CK("held off req", 1'b0, chip_reset_req)
		while (!chip_reset_req && n < 80) begin
			@(posedge aclk);
			n++;
		end
		`CK("req late", 1'b1, chip_reset_req)
		`CK("scope core", 1'b0, chip_reset_scope)
		rd(4'h8);
		`CK("late status", 1'b1, d[1])
		w(70);
	endtask

	// without reset enable an expired window leaves the chip alone
	task t_norst;
		wr(4'h0, 32'h00010004);
		wr(4'h0, 32'h00000080);
		w(40);
		rd(4'h0);
		`CK("no rst flag", 1'b0, d[2])
		`CK("no req", 1'b0, chip_reset_req)
		rd(4'h8);
		`CK("no rst status", 1'b0, d[1])
		wr(4'h0, 32'h00010000);
	endtask

	// reset, then the scenarios
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		t_lock;
		t_timeout;
		t_w1c;
		t_code;
		t_debug;
		t_clear;
		t_reset;
		t_window;
		t_norst;
		report_and_stop;
	end
endmodule
